// File: common/sradl_consts.svh
`ifndef SRADL_CONSTS_SVH
`define SRADL_CONSTS_SVH
`define SRADL_BUS_W       8
`define SRADL_ADDR_W      20
`define SRADL_LOW_W       4
`define SRADL_MEM_BYTES   20'h40000
`define SRADL_CARD_BIT    17
`define SRADL_ROW_LSB     14
`define SRADL_ROW_N       4
`define SRADL_COL_LSB     12
`define SRADL_COL_N       4
`define SRADL_HIGH_RST    8'h00
`define SRADL_MED_RST     8'h00
`define SRADL_SYNC_RST    3'h0
`endif

// File: common/sradl_pkg.sv
`default_nettype none
package sradl_pkg;
   typedef enum logic [1:0] {
      SRADL_IDLE,
      SRADL_READ,
      SRADL_WRITE
   } sradl_access_t;
   typedef logic [19:0] sradl_addr_t;
endpackage : sradl_pkg
`default_nettype wire

// File: hw/sradl_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "sradl_consts.svh"
module sradl_sync (
   input  wire logic i_core_clk,
   input  wire logic i_reset_n,
   input  wire logic i_async,
   output var  logic o_level,
   output var  logic o_rise
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic       level_reg;
   logic       level_next;
   logic       rise_reg;
   logic       rise_next;
   // ------------------------------------------------------------
   // Three stages, change counts when stages two and three agree
   // ------------------------------------------------------------
   always_comb begin
      sync_next  = {sync_reg[1:0], i_async};
      level_next = level_reg;
      rise_next  = 1'b0;
      if (sync_reg[1] == sync_reg[2]) begin
         level_next = sync_reg[2];
         rise_next  = sync_reg[2] & ~level_reg;
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         sync_reg  <= `SRADL_SYNC_RST;
         level_reg <= 1'b0;
         rise_reg  <= 1'b0;
      end else begin
         sync_reg  <= sync_next;
         level_reg <= level_next;
         rise_reg  <= rise_next;
      end
   end
   assign o_level = level_reg;
   assign o_rise  = rise_reg;
endmodule : sradl_sync
`default_nettype wire

// File: hw/sradl_top.sv
// Overview of operation
// - Twenty-bit memory address built from transfers over the eight-bit bus.
// - High-address strobe latches the bus byte as the top address portion.
// - Medium-address strobe latches the bus byte as the middle address portion.
// - Low address portion is never latched; taken live from the bus.
// - Decode table turns the address into selects, chip and write enables.
// - Card enable only inside memory range; it gates buffer and row decoder.
// - Row and column decoders flag devices when valid address is present.
// - Column selects drive output enables; row selects are chip enables.
// - Memory data reaches the bus only while the data strobe is active.
// - 256 Kbytes shown as two virtual cards, zero and one.
// - Phrase length includes leading and trailing silence; stored data, not logic.
`timescale 1ns/1ps
`default_nettype none
`include "sradl_consts.svh"
module sradl_top
   import sradl_pkg::*;
(
   input  wire logic                        i_core_clk,
   input  wire logic                        i_reset_n,
   input  wire logic [`SRADL_BUS_W-1:0]     i_bus_data,
   input  wire logic                        i_load_high,
   input  wire logic                        i_load_medium,
   input  wire logic                        i_data_select,
   input  wire logic                        i_write,
   input  wire logic [`SRADL_BUS_W-1:0]     i_mem_data,
   output var  logic [`SRADL_BUS_W-1:0]     o_bus_data,
   output var  logic                        o_bus_data_oe,
   output var  logic [`SRADL_ADDR_W-1:0]    o_mem_addr,
   output var  logic                        o_card_enable,
   output var  logic                        o_virtual_card,
   output var  logic [`SRADL_ROW_N-1:0]     o_row_ce_n,
   output var  logic [`SRADL_COL_N-1:0]     o_col_oe_n,
   output var  logic [`SRADL_ROW_N-1:0]     o_row_we_n
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic high_rise;
   logic med_rise;
   logic strobe_lvl;
   logic [`SRADL_BUS_W-1:0] bus_s0_reg;
   logic [`SRADL_BUS_W-1:0] bus_s1d_reg;
   logic [`SRADL_BUS_W-1:0] bus_s2_reg;
   logic [`SRADL_BUS_W-1:0] bus_data_reg;
   logic [`SRADL_BUS_W-1:0] bus_data_next;
   logic                    wr_s0_reg;
   logic                    wr_s1_reg;
   logic                    wr_s2_reg;
   logic                    wr_reg;
   logic                    wr_next;

   sradl_sync u_high (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_async    (i_load_high),
      .o_level    (),
      .o_rise     (high_rise)
   );
   sradl_sync u_med (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_async    (i_load_medium),
      .o_level    (),
      .o_rise     (med_rise)
   );
   sradl_sync u_strobe (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_async    (i_data_select),
      .o_level    (strobe_lvl),
      .o_rise     ()
   );

   // Bus word accepted only when stages two and three agree
   always_comb begin
      bus_data_next = (bus_s1d_reg == bus_s2_reg) ? bus_s2_reg : bus_data_reg;
      wr_next       = (wr_s1_reg == wr_s2_reg) ? wr_s2_reg : wr_reg;
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         bus_s0_reg   <= '0;
         bus_s1d_reg  <= '0;
         bus_s2_reg   <= '0;
         bus_data_reg <= '0;
         wr_s0_reg    <= 1'b0;
         wr_s1_reg    <= 1'b0;
         wr_s2_reg    <= 1'b0;
         wr_reg       <= 1'b0;
      end else begin
         bus_s0_reg   <= i_bus_data;
         bus_s1d_reg  <= bus_s0_reg;
         bus_s2_reg   <= bus_s1d_reg;
         bus_data_reg <= bus_data_next;
         wr_s0_reg    <= i_write;
         wr_s1_reg    <= wr_s0_reg;
         wr_s2_reg    <= wr_s1_reg;
         wr_reg       <= wr_next;
      end
   end

   // ------------------------------------------------------------
   // Address latches
   // ------------------------------------------------------------
   logic [`SRADL_BUS_W-1:0] high_reg;
   logic [`SRADL_BUS_W-1:0] high_next;
   logic [`SRADL_BUS_W-1:0] med_reg;
   logic [`SRADL_BUS_W-1:0] med_next;
   sradl_addr_t             addr;

   always_comb begin
      high_next = high_reg;
      med_next  = med_reg;
      if (high_rise) begin
         high_next = bus_data_reg;
      end
      if (med_rise) begin
         med_next = bus_data_reg;
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         high_reg <= `SRADL_HIGH_RST;
         med_reg  <= `SRADL_MED_RST;
      end else begin
         high_reg <= high_next;
         med_reg  <= med_next;
      end
   end

   // live low portion
   // Only the high byte's low nibble fits the twenty-bit word
   assign addr = {high_reg[`SRADL_LOW_W-1:0], med_reg, bus_data_reg};

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   sradl_access_t           acc;
   logic                    in_range;
   logic [1:0]              row_idx;
   logic [1:0]              col_idx;
   logic [`SRADL_ROW_N-1:0] row_sel;
   logic [`SRADL_COL_N-1:0] col_sel;

   always_comb begin
      acc      = SRADL_IDLE;
      in_range = (addr < `SRADL_MEM_BYTES);
      row_idx  = addr[`SRADL_ROW_LSB+1:`SRADL_ROW_LSB];
      col_idx  = addr[`SRADL_COL_LSB+1:`SRADL_COL_LSB];
      if (strobe_lvl && in_range) begin
         acc = wr_reg ? SRADL_WRITE : SRADL_READ;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `SRADL_ROW_N; g++) begin : g_sel
         assign row_sel[g] = in_range && (row_idx == 2'(g));
         assign col_sel[g] = in_range && (col_idx == 2'(g));
      end
   endgenerate

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   logic [`SRADL_BUS_W-1:0]  data_out_next;
   logic                     data_oe_next;
   logic [`SRADL_ROW_N-1:0]  row_ce_n_next;
   logic [`SRADL_COL_N-1:0]  col_oe_n_next;
   logic [`SRADL_ROW_N-1:0]  row_we_n_next;

   always_comb begin
      row_ce_n_next = '1;
      col_oe_n_next = '1;
      row_we_n_next = '1;
      data_oe_next  = 1'b0;
      data_out_next = o_bus_data;
      unique case (acc)
         SRADL_IDLE: begin
            data_out_next = o_bus_data;
         end
         SRADL_READ: begin
            // row as chip enable, column as output enable
            row_ce_n_next = ~row_sel;
            col_oe_n_next = ~col_sel;
            data_oe_next  = 1'b1;
            data_out_next = i_mem_data;
         end
         SRADL_WRITE: begin
            row_ce_n_next = ~row_sel;
            row_we_n_next = ~row_sel;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_mem_addr     <= '0;
         o_card_enable  <= 1'b0;
         o_virtual_card <= 1'b0;
         o_row_ce_n     <= '1;
         o_col_oe_n     <= '1;
         o_row_we_n     <= '1;
         o_bus_data_oe  <= 1'b0;
         o_bus_data     <= '0;
      end else begin
         o_mem_addr     <= addr;
         o_card_enable  <= in_range;
         o_virtual_card <= addr[`SRADL_CARD_BIT];
         o_row_ce_n     <= row_ce_n_next;
         o_col_oe_n     <= col_oe_n_next;
         o_row_we_n     <= row_we_n_next;
         o_bus_data_oe  <= data_oe_next;
         o_bus_data     <= data_out_next;
      end
   end
endmodule : sradl_top
`default_nettype wire

// File: bench/sradl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "sradl_consts.svh"
module sradl_asserts (
   input wire logic                     i_core_clk,
   input wire logic                     i_reset_n,
   input wire logic                     i_data_select,
   input wire logic                     o_bus_data_oe,
   input wire logic [`SRADL_ADDR_W-1:0] o_mem_addr,
   input wire logic                     o_card_enable,
   input wire logic                     o_virtual_card,
   input wire logic [`SRADL_ROW_N-1:0]  o_row_ce_n,
   input wire logic [`SRADL_COL_N-1:0]  o_col_oe_n,
   input wire logic [`SRADL_ROW_N-1:0]  o_row_we_n
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   a_card_range: assert property (o_card_enable |-> o_mem_addr < `SRADL_MEM_BYTES)
      else $error("card enable outside range");
   a_card_gate: assert property (!o_card_enable |-> &o_row_ce_n && !o_bus_data_oe)
      else $error("select without card enable");
   a_vcard_bit: assert property (o_virtual_card == o_mem_addr[17])
      else $error("virtual card bit wrong");
   a_row_decode: assert property (!(&o_row_ce_n) |-> o_row_ce_n == ~(4'h1 << o_mem_addr[15:14]))
      else $error("row select wrong");
   a_col_decode: assert property (!(&o_col_oe_n) |-> o_col_oe_n == ~(4'h1 << o_mem_addr[13:12]) && &o_row_we_n)
      else $error("column select wrong");
   a_col_row: assert property (!(&o_col_oe_n) |-> !(&o_row_ce_n))
      else $error("output enable without chip enable");
   a_we_row: assert property (!(&o_row_we_n) |-> o_row_we_n == o_row_ce_n)
      else $error("write enable off its row");
   a_oe_release: assert property ($fell(i_data_select) |-> ##[1:8] !o_bus_data_oe)
      else $error("bus still driven after strobe");
   a_sel_quiet: assert property (!i_data_select [*8] |-> &o_row_ce_n && !o_bus_data_oe)
      else $error("selects without strobe");
   c_read: cover property (o_bus_data_oe && o_virtual_card);
   c_write: cover property (!(&o_row_we_n));
   c_refuse: cover property (i_data_select && !o_card_enable);
endmodule : sradl_asserts
`default_nettype wire

// File: bench/sradl_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sradl_ctl_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_go,
   input  wire logic [7:0] i_high,
   input  wire logic [7:0] i_med,
   input  wire logic [7:0] i_low,
   input  wire logic       i_wr,
   input  wire logic [3:0] i_gap,
   output var  logic [7:0] o_bus_data,
   output var  logic       o_load_high,
   output var  logic       o_load_medium,
   output var  logic       o_data_select,
   output var  logic       o_write,
   output var  logic       o_busy
);
   // Gap sets pace; slow gaps mimic a lazy controller
   task automatic phase(input logic [7:0] d, input logic h, m, s, input int n);
      {o_bus_data, o_load_high, o_load_medium, o_data_select} = {d, h, m, s};
      repeat (n * i_gap) @(negedge i_core_clk);
   endtask : phase
   // One process owns every output, so each has a single driver
   initial begin
      {o_bus_data, o_load_high, o_load_medium, o_data_select, o_write, o_busy} = '0;
      forever begin
         @(posedge i_go);
         o_busy = 1'b1;
         phase(i_high, 1, 0, 0, 1);
         phase(i_high, 0, 0, 0, 1);
         phase(i_med, 0, 1, 0, 1);
         phase(i_med, 0, 0, 0, 1);
         o_write = i_wr;
         phase(i_low, 0, 0, 0, 1);
         phase(i_low, 0, 0, 1, 4);
         // Released bus: inverse, not last value
         o_write = 1'b0;
         phase(~i_low, 0, 0, 0, 1);
         o_busy = 1'b0;
      end
   end
endmodule : sradl_ctl_model
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rst_n, lh, lm, ds, wr, oe, ce, vc, busy;
   logic        go = 1'b0, wr_req = 1'b0;
   logic [7:0]  bus, o_bus, mem = 8'h00, high, med, low;
   logic [3:0]  gap = 4'h4, row_n, col_n, we_n;
   logic [19:0] addr;
   int          n_errors = 0, num_checks = 0;
   sradl_ctl_model ctl (.i_core_clk(clk), .i_go(go), .i_high(high), .i_med(med), .i_low(low), .i_wr(wr_req),
      .i_gap(gap), .o_bus_data(bus), .o_load_high(lh), .o_load_medium(lm), .o_data_select(ds), .o_write(wr),
      .o_busy(busy));
   sradl_top dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_bus_data(bus), .i_load_high(lh), .i_load_medium(lm),
      .i_data_select(ds), .i_write(wr), .i_mem_data(mem), .o_bus_data(o_bus), .o_bus_data_oe(oe),
      .o_mem_addr(addr), .o_card_enable(ce), .o_virtual_card(vc), .o_row_ce_n(row_n), .o_col_oe_n(col_n),
      .o_row_we_n(we_n));
   function automatic logic [3:0] dec(input int n);
      return ~(4'h1 << n);
   endfunction : dec
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   // Start an access, wait bounded for strobe and any select
   task automatic run(input logic [7:0] h, m, l, input logic w, input logic [3:0] g);
      int k;
      {high, med, low, wr_req, gap, go} = {h, m, l, w, g, 1'b1};
      @(negedge clk);
      go = 1'b0;
      for (k = 0; k < 150 && !ds; k++) @(negedge clk);
      for (k = 0; k < 10 && &row_n && &we_n; k++) @(negedge clk);
      @(negedge clk);
   endtask : run
   task automatic settle;
      int k;
      for (k = 0; k < 200 && busy; k++) @(negedge clk);
      for (k = 0; k < 10 && (oe || !(&row_n & &we_n)); k++) @(negedge clk);
      chk({oe, row_n, we_n}, {1'b0, 8'hFF});
   endtask : settle
   task automatic t_read;
      int r;
      logic [7:0] m;
      for (r = 0; r < 4; r++) begin
         m = {2'(r), 2'(3 - r), 4'h5};
         mem = 8'h5A ^ 8'(r);
         run({4'hA, 2'b00, r[0], 1'b0}, m, 8'h3C + 8'(r), 1'b0, r[0] ? 4'h6 : 4'h4);
         chk(addr, {2'b00, r[0], 1'b0, m, 8'h3C + 8'(r)});
         chk({vc, ce}, {r[0], 1'b1});
         chk({row_n, col_n, we_n}, {dec(r), dec(3 - r), 4'hF});
         chk({oe, o_bus}, {1'b1, mem});
         settle();
      end
      $display("t_read done");
   endtask : t_read
   task automatic t_write;
      run(8'h01, 8'h90, 8'h77, 1'b1, 4'h4);
      chk({we_n, row_n, col_n, oe}, {dec(2), dec(2), 4'hF, 1'b0});
      settle();
      $display("t_write done");
   endtask : t_write
   task automatic t_refuse;
      run(8'h03, 8'hFF, 8'hFF, 1'b0, 4'h4);
      chk({ce, vc, row_n, col_n}, {2'b11, dec(3), dec(3)});
      settle();
      run(8'h04, 8'h00, 8'h00, 1'b0, 4'h4);
      chk({ce, row_n, oe}, {1'b0, 4'hF, 1'b0});
      settle();
      $display("t_refuse done");
   endtask : t_refuse
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      chk({addr, row_n}, {20'h0, 4'hF});
      t_read();
      t_write();
      t_refuse();
      finish_test();
   end
   // Accesses take under 1000 cycles; allow ten times that
   initial begin
      #50000;
      n_errors++;
      finish_test();
   end
endmodule : tb
bind sradl_top sradl_asserts u_chk (.i_core_clk, .i_reset_n, .i_data_select, .o_bus_data_oe, .o_mem_addr,
   .o_card_enable, .o_virtual_card, .o_row_ce_n, .o_col_oe_n, .o_row_we_n);
`default_nettype wire
